// ### hcs_defs.svh
`ifndef HCS_DEFS_SVH
`define HCS_DEFS_SVH
// Overview of operation
// - Set_Configuration value drives configured bit 0.
// - Remote wakeup bit 1, feature requests, starts 0.
// - Bit 2 shows endpoint 0 halt.
// - Bit 3 shows endpoint 1 halt.
// - Endpoint 0 carries enumeration and configuration requests.
// - No endpoint descriptor for endpoint 0.
// - Endpoint 1 interrupt IN sends change bitmap.
// - Sample pending changes at EOF2 each frame.
// - Bitmap: bit0 hub, bits1-4 ports, rest zero.
// - Empty bitmap answers IN with NAK.
// - Nonzero bitmap answers IN with one byte.
// - Keep reporting change until host clears it.
// - No change reports before configuration.
// - Stop oscillator while suspended.
// - Controller state clears to zero at power-up.
// - 12 MHz frame timer restarts on SOF.

// ****************************************************************
// Controller state field positions
// ****************************************************************
`define HCS_CSR_CFG_BIT     0
`define HCS_CSR_RWAKE_BIT   1
`define HCS_CSR_EP0STL_BIT  2
`define HCS_CSR_EP1STL_BIT  3
`define HCS_CSR_RESET       4'h0

// ****************************************************************
// Change bitmap layout
// ****************************************************************
`define HCS_MAP_HUB_BIT     0
`define HCS_MAP_PORT_LSB    1
`define HCS_MAP_RSVD        3'h0
`define HCS_MAP_RESET       8'h00

// ****************************************************************
// Frame timing
// ****************************************************************
`define HCS_CLK_HZ          200_000_000
`define HCS_BIT_HZ          12_000_000
`define HCS_FRAME_BITS      12_000
`define HCS_EOF2_BITS       10
`endif

// ### hcs_frame_timer.sv
`include "hcs_defs.svh"
module hcs_frame_timer
  import hcs_pkg::*;
#(
  parameter int CLK_HZ     = `HCS_CLK_HZ,
  parameter int BIT_HZ     = `HCS_BIT_HZ,
  parameter int FRAME_BITS = `HCS_FRAME_BITS,
  parameter int EOF2_BITS  = `HCS_EOF2_BITS
) (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  // Link to controller
  hcs_timer_if.timer tmr
);
  localparam int AW = $clog2(CLK_HZ + BIT_HZ);
  localparam int CW = $clog2(FRAME_BITS + 1);
  localparam logic [AW-1:0] STEP = AW'(BIT_HZ);
  localparam logic [AW-1:0] WRAP = AW'(CLK_HZ);
  localparam logic [CW-1:0] EOF2_AT = CW'(FRAME_BITS - EOF2_BITS);
  localparam logic [CW-1:0] LAST = CW'(FRAME_BITS - 1);

  logic [AW-1:0] acc_q;
  logic [AW-1:0] acc_d;
  logic [CW-1:0] bit_cnt_q;
  logic [CW-1:0] bit_cnt_d;
  logic          eof2_q;
  logic          eof2_d;
  logic          tick;

  // ****************************************************************
  // Fractional 12 MHz bit tick
  // ****************************************************************
  // The system clock is no integer multiple of the bit rate, so a
  // phase accumulator keeps the long-term rate exact at the cost of
  // a little jitter on each tick.
  always_comb begin
    tick      = 1'b0;
    acc_d     = acc_q;
    bit_cnt_d = bit_cnt_q;
    eof2_d    = 1'b0;
    if (tmr.sof) begin
      acc_d     = '0;
      bit_cnt_d = '0;
    end else if (tmr.run) begin
      if (acc_q + STEP >= WRAP) begin
        acc_d = acc_q + STEP - WRAP;
        tick  = 1'b1;
      end else begin
        acc_d = acc_q + STEP;
      end
      if (tick) begin
        bit_cnt_d = (bit_cnt_q == LAST) ? '0 : bit_cnt_q + CW'(1);
        eof2_d    = (bit_cnt_d == EOF2_AT);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_q     <= '0;
      bit_cnt_q <= '0;
      eof2_q    <= 1'b0;
    end else begin
      acc_q     <= acc_d;
      bit_cnt_q <= bit_cnt_d;
      eof2_q    <= eof2_d;
    end
  end

  assign tmr.eof2 = eof2_q;
endmodule

// ### hcs_host_model.sv
module hcs_host_model #(
  parameter int PERIOD = 1666
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  output logic      sof_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  initial sof_o = 1'b0;
  // A steady frame start keeps the hub's timer from wrapping on its own.
  always @(posedge clk_i) begin
    cnt_q <= (reset_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    sof_o <= !reset_i && cnt_q == PERIOD - 1;
  end
endmodule

// ### hcs_hub_ctrl.sv
`include "hcs_defs.svh"
module hcs_hub_ctrl
  import hcs_pkg::*;
#(
  parameter int NUM_PORTS  = 4,
  parameter int FRAME_BITS = `HCS_FRAME_BITS
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  // Decoded endpoint 0 requests, one-cycle pulses
  input  wire logic                 set_config_i,
  input  wire logic [7:0]           config_value_i,
  input  wire logic                 set_rwake_i,
  input  wire logic                 clear_rwake_i,
  input  wire logic                 ep0_stall_i,
  input  wire logic                 ep0_setup_i,
  input  wire logic                 ep1_halt_set_i,
  input  wire logic                 ep1_halt_clear_i,
  // Token events from the serial engine
  input  wire logic                 sof_i,
  input  wire logic                 ep1_in_i,
  // Pending change flags, levels
  input  wire logic                 hub_change_i,
  input  wire logic [NUM_PORTS-1:0] port_change_i,
  // Power state
  input  wire logic                 suspend_i,
  // Endpoint 1 answer
  output logic                      ep1_nak_o,
  output logic                      ep1_stall_o,
  output logic                      ep1_data_valid_o,
  output logic [7:0]                ep1_data_o,
  // Status
  output logic [3:0]                ctrl_state_o,
  output logic [7:0]                change_map_o,
  output logic                      osc_run_o
);

  hcs_timer_if tmr_if ();

  // ****************************************************************
  // Frame timer
  // ****************************************************************
  // Only the frame length is overridden; the clock and bit rates
  // come from the shared constants.
  hcs_frame_timer #(
    .FRAME_BITS (FRAME_BITS)
  ) u_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tmr     (tmr_if.timer)
  );

  // The timer only counts while the hub is awake; a suspended hub
  // has no clock, so the frame position is simply held.
  assign tmr_if.sof = sof_i;
  assign tmr_if.run = ~suspend_i;

  // ****************************************************************
  // Controller state register
  // ****************************************************************
  logic [3:0] state_q;
  logic [3:0] state_d;

  // Endpoint 0 only ever answers control transfers; descriptor
  // contents, including the absence of an endpoint 0 descriptor,
  // live in the request engine outside this block.
  always_comb begin
    state_d = state_q;
    if (set_config_i) begin
      state_d[`HCS_CSR_CFG_BIT] = |config_value_i;
    end
    if (clear_rwake_i) begin
      state_d[`HCS_CSR_RWAKE_BIT] = 1'b0;
    end
    if (set_rwake_i) begin
      state_d[`HCS_CSR_RWAKE_BIT] = 1'b1;
    end
    // A new SETUP lifts the endpoint 0 halt; a stall in the same
    // cycle wins so that the event is never lost.
    if (ep0_setup_i) begin
      state_d[`HCS_CSR_EP0STL_BIT] = 1'b0;
    end
    if (ep0_stall_i) begin
      state_d[`HCS_CSR_EP0STL_BIT] = 1'b1;
    end
    // As for endpoint 0, a halt request beats a clear in one cycle.
    if (ep1_halt_clear_i) begin
      state_d[`HCS_CSR_EP1STL_BIT] = 1'b0;
    end
    if (ep1_halt_set_i) begin
      state_d[`HCS_CSR_EP1STL_BIT] = 1'b1;
    end
  end

  // Every bit of the controller state starts clear, so the hub comes
  // up unconfigured, without wakeup and with no endpoint halted.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= `HCS_CSR_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign ctrl_state_o = state_q;

  // ****************************************************************
  // Change bitmap
  // ****************************************************************
  logic [7:0] map_q;
  logic [7:0] map_d;
  logic [7:0] fresh_map;
  logic       configured;

  assign configured = state_q[`HCS_CSR_CFG_BIT];

  // Each port flag lands at its own bit above the hub bit; the bits
  // above the last port keep the reserved value of zero.
  always_comb begin
    fresh_map = `HCS_MAP_RESET;
    fresh_map[`HCS_MAP_HUB_BIT] = hub_change_i;
    for (int p = 0; p < NUM_PORTS; p++) begin
      fresh_map[`HCS_MAP_PORT_LSB + p] = port_change_i[p];
    end
  end

  // The bitmap is resampled every frame from the live change flags,
  // so a change stays reported until the host clears its flag.
  // Clearing it while unconfigured means that nothing is reported before
  // configuration; flags still pending then show at the first EOF2 after it.
  always_comb begin
    map_d = map_q;
    if (!configured) begin
      map_d = `HCS_MAP_RESET;
    end else if (tmr_if.eof2) begin
      map_d = fresh_map;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      map_q <= `HCS_MAP_RESET;
    end else begin
      map_q <= map_d;
    end
  end

  assign change_map_o = map_q;

  // ****************************************************************
  // Endpoint 1 answer
  // ****************************************************************
  hcs_answer_type ans_q;
  hcs_answer_type ans_d;
  logic [7:0]     data_q;
  logic [7:0]     data_d;

  logic           ep1_halted;
  logic           map_empty;

  assign ep1_halted = state_q[`HCS_CSR_EP1STL_BIT];
  assign map_empty  = (map_q == `HCS_MAP_RESET);

  // A halted endpoint answers STALL before anything else, so a host
  // that halted it never sees stale data. The data byte is left alone
  // on NAK and STALL; it shows the last byte sent, or zero before the first.
  // Endpoint 0 has no answer path here: it is served by the request
  // engine, which also owns the descriptors.
  always_comb begin
    ans_d  = HCS_ANS_NONE;
    data_d = data_q;
    if (ep1_in_i) begin
      if (ep1_halted) begin
        ans_d = HCS_ANS_STALL;
      end else if (!configured || map_empty) begin
        ans_d = HCS_ANS_NAK;
      end else begin
        ans_d  = HCS_ANS_DATA;
        data_d = map_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ans_q  <= HCS_ANS_NONE;
      data_q <= `HCS_MAP_RESET;
    end else begin
      ans_q  <= ans_d;
      data_q <= data_d;
    end
  end

  // Exactly one answer flag is high for one cycle after each token.
  assign ep1_nak_o        = (ans_q == HCS_ANS_NAK);
  assign ep1_stall_o      = (ans_q == HCS_ANS_STALL);
  assign ep1_data_valid_o = (ans_q == HCS_ANS_DATA);
  assign ep1_data_o       = data_q;

  // ****************************************************************
  // Oscillator control
  // ****************************************************************
  logic osc_q;
  logic osc_d;

  // The enable is registered so the pad driver sees a clean level;
  // the oscillator restarts one cycle after suspend is lifted.
  always_comb begin
    osc_d = ~suspend_i;
  end

  // Out of reset the oscillator runs, because a freshly powered hub
  // must be able to answer its enumeration at once.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_q <= 1'b1;
    end else begin
      osc_q <= osc_d;
    end
  end

  assign osc_run_o = osc_q;
endmodule

// ### hcs_hub_monitor.sv
module hcs_hub_monitor #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  // Requests and tokens
  input wire logic       set_config_i,
  input wire logic [7:0] config_value_i,
  input wire logic       set_rwake_i,
  input wire logic       clear_rwake_i,
  input wire logic       ep0_stall_i,
  input wire logic       ep0_setup_i,
  input wire logic       ep1_halt_set_i,
  input wire logic       ep1_halt_clear_i,
  input wire logic       sof_i,
  input wire logic       ep1_in_i,
  input wire logic       hub_change_i,
  input wire logic [NUM_PORTS-1:0] port_change_i,
  input wire logic       suspend_i,
  // Answers and status
  input wire logic       ep1_nak_o,
  input wire logic       ep1_stall_o,
  input wire logic       ep1_data_valid_o,
  input wire logic [7:0] ep1_data_o,
  input wire logic [3:0] ctrl_state_o,
  input wire logic [7:0] change_map_o,
  input wire logic       osc_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ****************
  // Checks
  // ****************
  cfg_set_a: assert property (
    set_config_i |=> ctrl_state_o[0] == |$past(config_value_i))
    else $error("configured bit wrong");
  wake_set_a: assert property (
    set_rwake_i |=> ctrl_state_o[1]) else $error("wakeup not set");
  ep0_halt_a: assert property (
    ep0_stall_i |=> ctrl_state_o[2]) else $error("ep0 halt not shown");
  ep1_halt_a: assert property (
    ep1_halt_set_i |=> ctrl_state_o[3]) else $error("ep1 halt not shown");
  stall_first_a: assert property (
    ep1_in_i && ctrl_state_o[3] |=> ep1_stall_o && !ep1_data_valid_o)
    else $error("halted endpoint not stalled");
  nak_empty_a: assert property (
    ep1_in_i && !ctrl_state_o[3] && change_map_o == 8'h00
    |=> ep1_nak_o && !ep1_data_valid_o) else $error("missing nak");
  data_send_a: assert property (
    ep1_in_i && ctrl_state_o[3:0] == 4'h1 && |change_map_o
    |=> ep1_data_valid_o && ep1_data_o == $past(change_map_o))
    else $error("bitmap not sent");
  map_rsvd_a: assert property (
    change_map_o[7:5] == 3'h0) else $error("reserved bits set");
  unconf_map_a: assert property (
    !ctrl_state_o[0] && !set_config_i |=> change_map_o == 8'h00)
    else $error("map shown while unconfigured");
  osc_stop_a: assert property (
    1'b1 |=> osc_run_o == !$past(suspend_i)) else $error("osc wrong");
  cover property (ep1_in_i ##1 ep1_data_valid_o);
  cover property (ep1_in_i ##1 ep1_nak_o);
  cover property (ep1_in_i ##1 ep1_stall_o);
endmodule

// ### hcs_pkg.sv
package hcs_pkg;
  typedef enum logic [1:0] {
    HCS_ANS_NONE  = 2'b00,
    HCS_ANS_NAK   = 2'b01,
    HCS_ANS_STALL = 2'b10,
    HCS_ANS_DATA  = 2'b11
  } hcs_answer_type;
endpackage

// ### hcs_timer_if.sv
interface hcs_timer_if;
  logic sof;
  logic run;
  logic eof2;
  modport ctrl  (output sof, output run, input eof2);
  modport timer (input sof, input run, output eof2);
endinterface

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FB = 100;
  logic       clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic [7:0] rq = 8'h00;
  logic [7:0] cv = 8'h00;
  logic       sof_i;
  logic       hub_change_i = 1'b0;
  logic [3:0] port_change_i = 4'h0;
  logic       suspend_i = 1'b0;
  logic       ep1_nak_o, ep1_stall_o, ep1_data_valid_o, osc_run_o;
  logic [7:0] ep1_data_o, change_map_o;
  logic [3:0] ctrl_state_o;
  logic [7:0] steps[6] = '{8'h01, 8'h13, 8'h21, 8'h35, 8'h41, 8'h59};
  int         bad_count = 0;
  int         checked = 0;
  hcs_hub_ctrl #(.FRAME_BITS(FB)) DUT (
    .clk_i, .reset_i, .set_config_i(rq[0]), .config_value_i(cv),
    .set_rwake_i(rq[1]), .clear_rwake_i(rq[2]), .ep0_stall_i(rq[3]),
    .ep0_setup_i(rq[4]), .ep1_halt_set_i(rq[5]),
    .ep1_halt_clear_i(rq[6]), .sof_i, .ep1_in_i(rq[7]), .hub_change_i,
    .port_change_i, .suspend_i, .ep1_nak_o, .ep1_stall_o,
    .ep1_data_valid_o, .ep1_data_o, .ctrl_state_o, .change_map_o,
    .osc_run_o);
  hcs_host_model #(.PERIOD(FB * 200 / 12)) host (
    .clk_i, .reset_i, .sof_o(sof_i));
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int b, input logic [7:0] v = 8'h01);
    @(posedge clk_i);
    rq[b] <= 1'b1;
    cv <= v;
    @(posedge clk_i);
    rq[b] <= 1'b0;
    #1;
  endtask
  task automatic token(input logic [2:0] a, input logic [7:0] d);
    pulse(7);
    chk({5'h0, ep1_stall_o, ep1_nak_o, ep1_data_valid_o}, {5'h0, a});
    if (a[0]) chk(ep1_data_o, d);
  endtask
  task automatic wait_map(input logic [7:0] exp);
    for (int i = 0; i < 4000 && change_map_o !== exp; i++) begin
      @(posedge clk_i);
      #1;
    end
    #1;
    chk(change_map_o, exp);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    chk({4'h0, ctrl_state_o}, 8'h00);
    @(posedge clk_i);
    port_change_i <= 4'h4;
    hub_change_i <= 1'b1;
    // Over two frames pass so a leak of the bitmap would surely show.
    repeat (4000) @(posedge clk_i);
    #1;
    chk(change_map_o, 8'h00);
    token(3'b010, 8'h00);
    $display("test unconfigured done");
    foreach (steps[i]) begin
      pulse(int'(steps[i][7:4]));
      chk({4'h0, ctrl_state_o}, {4'h0, steps[i][3:0]});
    end
    token(3'b100, 8'h00);
    pulse(6);
    chk({4'h0, ctrl_state_o}, 8'h01);
    $display("test state done");
    wait_map(8'h09);
    token(3'b001, 8'h09);
    token(3'b001, 8'h09);
    @(posedge clk_i);
    port_change_i <= 4'h0;
    hub_change_i <= 1'b0;
    wait_map(8'h00);
    token(3'b010, 8'h00);
    $display("test bitmap done");
    @(posedge clk_i);
    suspend_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk({7'h0, osc_run_o}, 8'h00);
    @(posedge clk_i);
    suspend_i <= 1'b0;
    pulse(0, 8'h00);
    chk({4'h0, ctrl_state_o}, 8'h00);
    $display("test power done");
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
bind hcs_hub_ctrl hcs_hub_monitor #(.NUM_PORTS(NUM_PORTS)) mon (
  .clk_i, .reset_i, .set_config_i, .config_value_i, .set_rwake_i,
  .clear_rwake_i, .ep0_stall_i, .ep0_setup_i, .ep1_halt_set_i,
  .ep1_halt_clear_i, .sof_i, .ep1_in_i, .hub_change_i, .port_change_i,
  .suspend_i, .ep1_nak_o, .ep1_stall_o, .ep1_data_valid_o, .ep1_data_o,
  .ctrl_state_o, .change_map_o, .osc_run_o);
